// >>> adc_far_side.sv
// far-side model: converter sequencing strobes and analog sample path
`timescale 1ns/1ps
`default_nettype none
module adc_far_side
(
  input  wire logic [1:0]  first_cmd,
  input  wire logic [1:0]  second_cmd,
  input  wire logic [4:0]  first_scan_channel,
  input  wire logic        first_low_reference,
  input  wire logic [31:0] first_mux_ground,
  output logic             first_scan_restart,
  output logic             first_scan_advance,
  output logic             second_scan_restart,
  output logic             second_scan_advance,
  output logic      [7:0]  first_sample
);
  // strobes follow the bench's registered commands, so they change just after an edge
  assign first_scan_restart  = first_cmd[0];
  assign first_scan_advance  = first_cmd[1];
  assign second_scan_restart = second_cmd[0];
  assign second_scan_advance = second_cmd[1];

  // pin n carries level n+1, so a grounded or absent input shows as 0
  always_comb
  begin
    if (first_low_reference || first_mux_ground[first_scan_channel])
      first_sample = 8'h00;
    else
      first_sample = {3'h0, first_scan_channel} + 8'h01;
  end
endmodule : adc_far_side
`default_nettype wire

// >>> adc_scan_config.sv
// scan-select and pin analog configuration registers with scan sequencing
`timescale 1ns/1ps
`default_nettype none
module adc_scan_config
  import adc_scan_pkg::*;
#(
  parameter int unsigned PRESENT = 32
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              first_scan_restart,
  input  wire logic              first_scan_advance,
  input  wire logic              second_scan_restart,
  input  wire logic              second_scan_advance,
  output logic      [4:0]        first_scan_channel,
  output logic                   first_scan_valid,
  output logic                   first_low_reference,
  output logic      [3:0]        second_scan_channel,
  output logic                   second_scan_valid,
  output logic                   second_low_reference,
  output logic      [31:0]       pin_digital_mode,
  output logic      [31:0]       first_mux_ground,
  output logic      [15:0]       second_mux_ground
);

  logic [15:0] scan_select_high;
  logic [15:0] scan_select_low;
  logic [15:0] pin_analog_config_high;
  logic [15:0] pin_analog_config_low;
  logic [15:0] second_converter_pin_config_low;
  logic [15:0] second_scan_select_low;
  logic [15:0] converter_module_disable;
  logic [15:0] scan_status;
  logic [15:0] next_rdata;

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scan_select_high       <= RESET_SCAN_SELECT;
      scan_select_low        <= RESET_SCAN_SELECT;
      second_scan_select_low <= RESET_SCAN_SELECT;
    end
    else if (reg_write)
    begin
      // every bit stays writable even for absent inputs
      if (reg_addr == OFS_SCAN_SELECT_HIGH)
        scan_select_high <= reg_wdata;
      if (reg_addr == OFS_SCAN_SELECT_LOW)
        scan_select_low <= reg_wdata;
      if (reg_addr == OFS_SECOND_SCAN_SELECT_LOW)
        second_scan_select_low <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_analog_config_high          <= RESET_PIN_CONFIG;
      pin_analog_config_low           <= RESET_PIN_CONFIG;
      second_converter_pin_config_low <= RESET_PIN_CONFIG;
    end
    else if (reg_write)
    begin
      if (reg_addr == OFS_PIN_ANALOG_CONFIG_HIGH)
        pin_analog_config_high <= reg_wdata;
      if (reg_addr == OFS_PIN_ANALOG_CONFIG_LOW)
        pin_analog_config_low <= reg_wdata;
      if (reg_addr == OFS_SECOND_PIN_CONFIG_LOW)
        second_converter_pin_config_low <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      converter_module_disable <= RESET_CONTROL;
    else if (reg_write && reg_addr == OFS_MODULE_CONTROL)
      converter_module_disable <= {14'h0000, reg_wdata[1:0]};
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------
  always_comb
  begin
    scan_status = '0;
    scan_status[STS_FIRST_CHAN_LSB +: 5]  = first_scan_channel;
    scan_status[STS_SECOND_CHAN_LSB +: 4] = second_scan_channel;
    scan_status[STS_FIRST_VALID_BIT]      = first_scan_valid;
    scan_status[STS_SECOND_VALID_BIT]     = second_scan_valid;
  end

  always_comb
  begin
    unique case (reg_addr)
      OFS_SCAN_SELECT_HIGH:       next_rdata = scan_select_high;
      OFS_SCAN_SELECT_LOW:        next_rdata = scan_select_low;
      OFS_PIN_ANALOG_CONFIG_HIGH: next_rdata = pin_analog_config_high;
      OFS_PIN_ANALOG_CONFIG_LOW:  next_rdata = pin_analog_config_low;
      OFS_SECOND_PIN_CONFIG_LOW:  next_rdata = second_converter_pin_config_low;
      OFS_SECOND_SCAN_SELECT_LOW: next_rdata = second_scan_select_low;
      OFS_MODULE_CONTROL:         next_rdata = converter_module_disable;
      OFS_SCAN_STATUS:            next_rdata = scan_status;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (reg_read)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= '0;
  end

  // ------------------------------------------------------------------
  // scan sequencing
  // ------------------------------------------------------------------
  scan_sequencer #(
    .N_IN    (MAX_IN),
    .PRESENT (PRESENT)
  ) u_first_scan (
    .clk          (clk),
    .rst          (rst),
    .select_bits  ({scan_select_high, scan_select_low}),
    .scan_restart (first_scan_restart),
    .scan_advance (first_scan_advance),
    .scan_channel (first_scan_channel),
    .scan_valid   (first_scan_valid),
    .scan_absent  (first_low_reference)
  );

  // second converter is only ever 16 wide, so inputs above 15 cannot be picked
  scan_sequencer #(
    .N_IN    (SECOND_IN),
    .PRESENT ((PRESENT < SECOND_IN) ? PRESENT : SECOND_IN)
  ) u_second_scan (
    .clk          (clk),
    .rst          (rst),
    .select_bits  (second_scan_select_low),
    .scan_restart (second_scan_restart),
    .scan_advance (second_scan_advance),
    .scan_channel (second_scan_channel),
    .scan_valid   (second_scan_valid),
    .scan_absent  (second_low_reference)
  );

  // ------------------------------------------------------------------
  // pin modes
  // ------------------------------------------------------------------
  pin_mode_map #(
    .PRESENT (PRESENT)
  ) u_pin_map (
    .first_config      ({pin_analog_config_high, pin_analog_config_low}),
    .second_config     (second_converter_pin_config_low),
    .first_disable     (converter_module_disable[CTL_FIRST_DISABLE_BIT]),
    .second_disable    (converter_module_disable[CTL_SECOND_DISABLE_BIT]),
    .pin_digital_mode  (pin_digital_mode),
    .first_mux_ground  (first_mux_ground),
    .second_mux_ground (second_mux_ground)
  );

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic [31:0] first_select;
  logic [31:0] present_pins;
  assign first_select = {scan_select_high, scan_select_low};

  // own copy of the present-input mask so checks do not lean on the map
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      present_pins[i] = (i < PRESENT);
  end

  // one edge after reset is seen, so power-up unknowns are never judged
  property p_reset_clear;
    @(posedge clk) rst |=> (first_select == 32'h0 && pin_digital_mode == 32'h0
                                    && second_scan_select_low == 16'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("regs not cleared by reset");

  property p_high_write;
    @(posedge clk) disable iff (rst)
      reg_write && reg_addr == OFS_SCAN_SELECT_HIGH
      ##1 reg_read && reg_addr == OFS_SCAN_SELECT_HIGH
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high scan write lost");

  property p_low_write;
    @(posedge clk) disable iff (rst)
      reg_write && reg_addr == OFS_SCAN_SELECT_LOW |=> scan_select_low == $past(reg_wdata);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low scan write lost");

  property p_advance_selected;
    @(posedge clk) disable iff (rst)
      first_scan_advance && first_scan_valid && !first_scan_restart
      && reg_write == 1'b0 |=> first_select[first_scan_channel];
  endproperty
  a_advance_selected: assert property (p_advance_selected) else $error("scan hit a skipped input");

  property p_ascending;
    @(posedge clk) disable iff (rst)
      first_scan_advance && !first_scan_restart && !reg_write
      && first_select[first_scan_channel] && $countones(first_select) > 1
      && (first_select >> first_scan_channel) > 32'h1
      |=> first_scan_channel > $past(first_scan_channel);
  endproperty
  a_ascending: assert property (p_ascending) else $error("scan not ascending");

  property p_digital_pin;
    @(posedge clk) disable iff (rst)
      pin_analog_config_low[0] && PRESENT > 0 |-> pin_digital_mode[0] && first_mux_ground[0];
  endproperty
  a_digital_pin: assert property (p_digital_pin) else $error("pin bit set but not digital");

  property p_analog_pin;
    @(posedge clk) disable iff (rst)
      !pin_analog_config_low[1] && !second_converter_pin_config_low[1]
      && converter_module_disable[1:0] == 2'b00 |-> !pin_digital_mode[1];
  endproperty
  a_analog_pin: assert property (p_analog_pin) else $error("pin bit clear but digital");

  property p_disable_digital;
    @(posedge clk) disable iff (rst)
      converter_module_disable[CTL_FIRST_DISABLE_BIT]
      |-> first_mux_ground == present_pins && pin_digital_mode == present_pins;
  endproperty
  a_disable_digital: assert property (p_disable_digital) else $error("disabled pins not digital");

  property p_absent_ref;
    @(posedge clk) disable iff (rst)
      first_low_reference |-> 32'(first_scan_channel) >= PRESENT
                              && !pin_digital_mode[first_scan_channel];
  endproperty
  a_absent_ref: assert property (p_absent_ref) else $error("absent input flag wrong");

  property p_absent_pin;
    @(posedge clk) disable iff (rst)
      ((pin_digital_mode | first_mux_ground) & ~present_pins) == 32'h0;
  endproperty
  a_absent_pin: assert property (p_absent_pin) else $error("absent pin driven");

  property p_restart_lowest;
    @(posedge clk) disable iff (rst)
      first_scan_restart && first_scan_valid && !reg_write
      |=> first_select[first_scan_channel]
          && (first_select & ((32'h1 << first_scan_channel) - 32'h1)) == 32'h0;
  endproperty
  a_restart_lowest: assert property (p_restart_lowest) else $error("restart missed lowest");

  property p_second_shared;
    @(posedge clk) disable iff (rst)
      !converter_module_disable[CTL_SECOND_DISABLE_BIT]
      |-> second_mux_ground == (second_converter_pin_config_low & present_pins[15:0])
          && (second_mux_ground & ~pin_digital_mode[15:0]) == 16'h0000;
  endproperty
  a_second_shared: assert property (p_second_shared) else $error("shared pin mode wrong");

  // read data must not linger, software may poll any index
  property p_rdata_idle;
    @(posedge clk) disable iff (rst)
      !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");

  c_scan_wrap: cover property (@(posedge clk) disable iff (rst)
    first_scan_advance && first_scan_valid ##1 first_scan_channel < $past(first_scan_channel));
  c_second_scan: cover property (@(posedge clk) disable iff (rst)
    second_scan_advance && second_scan_valid);
  c_pin_digital: cover property (@(posedge clk) disable iff (rst) pin_digital_mode[15]);
  c_disable: cover property (@(posedge clk) disable iff (rst) converter_module_disable[1]);

endmodule : adc_scan_config
`default_nettype wire

// >>> adc_scan_config_test.sv
// self-checking bench for the scan-select and pin configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_scan_config_test;
  import adc_scan_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  // a part with 20 inputs exercises the absent-input paths
  localparam int unsigned PRESENT = 20;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_write = 1'b0;
  logic              reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [1:0]        first_cmd = 2'h0;
  logic [1:0]        second_cmd = 2'h0;
  logic              f_rs, f_ad, s_rs, s_ad;
  logic [4:0]        f_ch;
  logic              f_val, f_low;
  logic [3:0]        s_ch;
  logic              s_val, s_low;
  logic [31:0]       pdm, fmg;
  logic [15:0]       smg;
  logic [7:0]        f_smp;
  int                bad_count = 0;
  int                samples_checked = 0;

  always #2 clk = ~clk;

  adc_scan_config #(.PRESENT(PRESENT)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .first_scan_restart(f_rs), .first_scan_advance(f_ad), .second_scan_restart(s_rs),
    .second_scan_advance(s_ad), .first_scan_channel(f_ch), .first_scan_valid(f_val),
    .first_low_reference(f_low), .second_scan_channel(s_ch), .second_scan_valid(s_val),
    .second_low_reference(s_low), .pin_digital_mode(pdm), .first_mux_ground(fmg),
    .second_mux_ground(smg));

  adc_far_side far (.first_cmd(first_cmd), .second_cmd(second_cmd), .first_scan_channel(f_ch),
    .first_low_reference(f_low), .first_mux_ground(fmg), .first_scan_restart(f_rs),
    .first_scan_advance(f_ad), .second_scan_restart(s_rs), .second_scan_advance(s_ad),
    .first_sample(f_smp));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input int a, input logic [15:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= 3'(a);
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_check(input int a, input logic [15:0] exp);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= 3'(a);
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check({16'h0, reg_rdata}, {16'h0, exp});
  endtask : rd_check

  // kind: bit0 restart, bit1 advance; first converter when sel is 0
  task automatic step(input logic sel, input logic [1:0] kind);
    @(posedge clk);
    if (sel) second_cmd <= kind;
    else first_cmd <= kind;
    @(posedge clk);
    first_cmd  <= 2'h0;
    second_cmd <= 2'h0;
    #1;
  endtask : step

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_values;
    for (int i = 0; i < 7; i++) rd_check(i, 16'h0000);
    check(pdm, 32'h0);
    check({30'h0, f_val, s_val}, 32'h0);
  endtask : test_reset_values

  task automatic test_readback;
    logic [15:0] v;
    for (int i = 0; i < 7; i++)
    begin
      v = 16'(16'h1111 * (i + 1));
      wr(i, v);
      rd_check(i, (i == 6) ? (v & 16'h0003) : v);
    end
  endtask : test_readback

  task automatic test_back_to_back;
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= OFS_SCAN_SELECT_HIGH;
    reg_wdata <= 16'h5a3c;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clk);
    reg_read  <= 1'b0;
    #1;
    check({16'h0, reg_rdata}, 32'h00005a3c);
    @(posedge clk);
    #1;
    check({16'h0, reg_rdata}, 32'h0);
  endtask : test_back_to_back

  task automatic test_pins;
    wr(3, 16'h00a4);
    wr(2, 16'hffff);
    check(pdm, 32'h000f00a4);
    check(fmg, 32'h000f00a4);
    wr(4, 16'h0f00);
    check(pdm, 32'h000f0fa4);
    check({16'h0, smg}, 32'h00000f00);
    wr(2, 16'h0000);
    wr(6, 16'h0001);
    check(pdm, 32'h000fffff);
    wr(6, 16'h0002);
    check(pdm, 32'h0000ffff);
    wr(6, 16'h0000);
  endtask : test_pins

  task automatic test_scan;
    wr(1, 16'h0005);
    wr(0, 16'h0011);
    step(1'b0, 2'h1);
    check({18'h0, f_val, f_ch, f_smp}, {18'h0, 1'b1, 5'd0, 8'h01});
    step(1'b0, 2'h2);
    check({19'h0, f_ch, f_smp}, {19'h0, 5'd2, 8'h00});
    step(1'b0, 2'h2);
    check({26'h0, f_ch, f_low}, {26'h0, 5'd16, 1'b0});
    step(1'b0, 2'h2);
    check({18'h0, f_ch, f_low, f_smp}, {18'h0, 5'd20, 1'b1, 8'h00});
    step(1'b0, 2'h2);
    check({27'h0, f_ch}, 32'd0);
    wr(5, 16'h8001);
    step(1'b1, 2'h1);
    check({27'h0, s_val, s_ch}, {27'h0, 1'b1, 4'd0});
    step(1'b1, 2'h2);
    check({27'h0, s_ch, s_low}, {27'h0, 4'd15, 1'b0});
    step(1'b1, 2'h2);
    check({28'h0, s_ch}, 32'd0);
    step(1'b0, 2'h2);
    wr(1, 16'h0000);
    wr(0, 16'h0000);
    check({31'h0, f_val}, 32'h0);
    step(1'b0, 2'h2);
    check({27'h0, f_ch}, 32'd2);
    rd_check(7, 16'h8002);
  endtask : test_scan

  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_reset_values();
    test_readback();
    test_back_to_back();
    do_reset();
    test_reset_values();
    test_pins();
    test_scan();
    conclude();
  end

  initial
  begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule : adc_scan_config_test
`default_nettype wire

// >>> adc_scan_pkg.sv
// constants shared by the scan-select and pin analog configuration block
package adc_scan_pkg;

  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned MAX_IN    = 32;
  localparam int unsigned SECOND_IN = 16;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [2:0] OFS_SCAN_SELECT_HIGH          = 3'h0;
  localparam logic [2:0] OFS_SCAN_SELECT_LOW           = 3'h1;
  localparam logic [2:0] OFS_PIN_ANALOG_CONFIG_HIGH    = 3'h2;
  localparam logic [2:0] OFS_PIN_ANALOG_CONFIG_LOW     = 3'h3;
  localparam logic [2:0] OFS_SECOND_PIN_CONFIG_LOW     = 3'h4;
  localparam logic [2:0] OFS_SECOND_SCAN_SELECT_LOW    = 3'h5;
  localparam logic [2:0] OFS_MODULE_CONTROL            = 3'h6;
  localparam logic [2:0] OFS_SCAN_STATUS               = 3'h7;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTL_FIRST_DISABLE_BIT  = 0;
  localparam int unsigned CTL_SECOND_DISABLE_BIT = 1;
  localparam int unsigned STS_FIRST_CHAN_LSB     = 0;
  localparam int unsigned STS_SECOND_CHAN_LSB    = 8;
  localparam int unsigned STS_FIRST_VALID_BIT    = 14;
  localparam int unsigned STS_SECOND_VALID_BIT   = 15;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [15:0] RESET_SCAN_SELECT = 16'h0000;
  localparam logic [15:0] RESET_PIN_CONFIG  = 16'h0000;
  localparam logic [15:0] RESET_CONTROL     = 16'h0000;

endpackage : adc_scan_pkg

// >>> pin_mode_map.sv
// merges both converters' pin configuration into per-pin mode controls
`timescale 1ns/1ps
`default_nettype none
module pin_mode_map
  import adc_scan_pkg::*;
#(
  parameter int unsigned PRESENT = 32
)(
  input  wire logic [31:0] first_config,
  input  wire logic [15:0] second_config,
  input  wire logic        first_disable,
  input  wire logic        second_disable,
  output logic      [31:0] pin_digital_mode,
  output logic      [31:0] first_mux_ground,
  output logic      [15:0] second_mux_ground
);

  logic [31:0] present_mask;
  logic [31:0] first_eff;
  logic [31:0] second_eff;

  always_comb
  begin
    for (int i = 0; i < 32; i++)
      present_mask[i] = (i < PRESENT);
  end

  // a disabled converter forces all its pins digital
  assign first_eff  = first_config | {32{first_disable}};
  assign second_eff = {16'h0000, second_config | {16{second_disable}}};

  // both converters may claim the low pins; any digital claim wins
  assign pin_digital_mode  = (first_eff | second_eff) & present_mask;
  assign first_mux_ground  = first_eff & present_mask;
  assign second_mux_ground = second_eff[15:0] & present_mask[15:0];

endmodule : pin_mode_map
`default_nettype wire

// >>> scan_sequencer.sv
// walks the selected analog inputs in ascending order with wrap-around
`timescale 1ns/1ps
`default_nettype none
module scan_sequencer
  import adc_scan_pkg::*;
#(
  parameter int unsigned N_IN    = 32,
  parameter int unsigned PRESENT = 32,
  localparam int unsigned CW     = $clog2(N_IN)
)(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [N_IN-1:0] select_bits,
  input  wire logic            scan_restart,
  input  wire logic            scan_advance,
  output logic      [CW-1:0]   scan_channel,
  output logic                 scan_valid,
  output logic                 scan_absent
);

  // first selected input strictly after 'from', wrapping past the top
  function automatic logic [CW-1:0] next_selected(input logic [N_IN-1:0] sel,
                                                  input logic [CW-1:0]   from);
    logic [CW-1:0] idx;
    logic          hit;
    next_selected = from;
    hit = 1'b0;
    for (int i = 1; i <= N_IN; i++)
    begin
      idx = CW'((int'(from) + i) % N_IN);
      if (!hit && sel[idx])
      begin
        next_selected = idx;
        hit = 1'b1;
      end
    end
  endfunction : next_selected

  assign scan_valid = |select_bits;

  always_ff @(posedge clk)
  begin
    if (rst)
      scan_channel <= '0;
    else if (scan_restart && scan_valid)
      scan_channel <= next_selected(select_bits, CW'(N_IN - 1));
    else if (scan_advance && scan_valid)
      scan_channel <= next_selected(select_bits, scan_channel);
  end

  // absent inputs convert the low reference instead of a pin
  assign scan_absent = (int'(scan_channel) >= PRESENT);

endmodule : scan_sequencer
`default_nettype wire
